// *** include/pch_defines.svh ***
// Purpose: constants of the programming-mode command handler
// Assumes: included by the package and by the design modules
// Notes: timing counts derive from the clock rate
`ifndef PCH_DEFINES_SVH
`define PCH_DEFINES_SVH

// frame layout
`define PCH_START_PAT 3'b010
`define PCH_SENSOR_SEL 3'b001
`define PCH_SHORT_MSG_BITS 5'd6
`define PCH_LONG_MSG_BITS 5'd16
`define PCH_CRC_BITS 5'd3
`define PCH_FC_BIT_IDX 5'd5
`define PCH_CRC_SEED 3'b111
`define PCH_CRC_POLY 3'b011

// function field codes
`define PCH_FC_XL0 3'b000
`define PCH_FC_XL1 3'b001
`define PCH_FC_READ 3'b010
`define PCH_FC_WRITE 3'b011
`define PCH_FC_EXEC 3'b100
`define PCH_FC_BAD1 3'b101
`define PCH_FC_BAD2 3'b110
`define PCH_FC_ENTER 3'b111

// reply words
`define PCH_RC_OK 10'h1e1
`define PCH_RC_ERR 10'h1e2
`define PCH_RD_EXEC_OK 10'h2aa
`define PCH_RD_ENTER_OK 10'h0ca
`define PCH_RD_ZERO 10'h000
`define PCH_WORDS_SHORT 2'd2
`define PCH_WORDS_LONG 2'd3

// fault numbers
`define PCH_FAULT_FRAMING 4'h1
`define PCH_FAULT_CRC 4'h2
`define PCH_FAULT_RANGE 4'h5
`define PCH_FAULT_WPROT 4'h6

// register array
`define PCH_ARRAY_BYTES 32
`define PCH_VALID_NIBBLES 64
`define PCH_LAST_BYTE 5'h1f
`define PCH_PROT_BYTES 5'h02
`define PCH_SC_BYTE 5'h0e
`define PCH_LOAD_OK_BIT 0

// timing
`define PCH_CLK_MHZ 100
`define PCH_PROG_DELAY_US 100
`define PCH_PROG_DELAY_CYC (`PCH_PROG_DELAY_US * `PCH_CLK_MHZ)
`define PCH_BYTE_WRITE_US 10
`define PCH_BYTE_WRITE_CYC (`PCH_BYTE_WRITE_US * `PCH_CLK_MHZ)

`endif

// *** include/pch_pkg.sv ***
// Purpose: types of the programming-mode command handler
// Assumes: pch_defines.svh on the include path
// Notes: state of each module is one packed struct
`include "pch_defines.svh"

package pch_pkg;

    typedef logic [9:0] pch_word_t;
    typedef logic [7:0] pch_byte_t;
    typedef logic [2:0][9:0] pch_words_t;
    typedef logic [`PCH_ARRAY_BYTES-1:0][7:0] pch_array_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_DATA = 2'b01,
        RX_REPLY = 2'b10
    } pch_rx_e;

    typedef enum logic [1:0] {
        OTP_IDLE = 2'b00,
        OTP_DELAY = 2'b01,
        OTP_WRITE = 2'b10,
        OTP_REFRESH = 2'b11
    } pch_otp_e;

    typedef struct packed {
        pch_rx_e state;
        logic [2:0] hist;
        logic sync_seen;
        logic [1:0] grp;
        logic [4:0] nbits;
        logic [15:0] msg;
        logic [2:0] crc;
        logic [2:0] rxcrc;
        pch_words_t words;
        logic [1:0] nwords;
        logic [1:0] widx;
        logic reply_stb;
        pch_word_t reply_word;
        logic reply_par;
        logic prog;
        logic lock;
        logic otp_start;
        pch_array_t shadow;
    } pch_top_s;

    typedef struct packed {
        pch_otp_e state;
        logic [19:0] cnt;
        logic [4:0] idx;
        logic mism;
        logic done;
        logic ok;
        pch_array_t otp;
    } pch_seq_s;

endpackage : pch_pkg

// *** include/pch_otp_if.sv ***
// Purpose: link between command handler and one-time array sequencer
// Assumes: both ends on the same clock
// Notes: idx addresses the shadow byte during write and refresh
`timescale 1ns/1ns

interface pch_otp_if;
    logic start;
    logic [7:0] shadow_byte;
    logic [4:0] idx;
    logic writing;
    logic refresh_we;
    logic [7:0] refresh_data;
    logic done;
    logic ok;

    modport ctrl (
        output start,
        output shadow_byte,
        input idx,
        input writing,
        input refresh_we,
        input refresh_data,
        input done,
        input ok
    );

    modport seq (
        input start,
        input shadow_byte,
        output idx,
        output writing,
        output refresh_we,
        output refresh_data,
        output done,
        output ok
    );
endinterface : pch_otp_if

// *** rtl/pch_otp_seq.sv ***
// Purpose: one-time array write, verify and shadow refresh sequence
// Assumes: start is a one-cycle pulse from the command handler
// Notes: array bits can only be set; a set array bit that the shadow byte holds clear flags a mismatch
`timescale 1ns/1ns
`include "pch_defines.svh"

module pch_otp_seq #(
    parameter int unsigned PROG_DELAY_CYC = `PCH_PROG_DELAY_CYC,
    parameter int unsigned BYTE_WRITE_CYC = `PCH_BYTE_WRITE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // handler side
    pch_otp_if.seq bus
);
    import pch_pkg::*;

    pch_seq_s s_q;
    pch_seq_s s_d;
    pch_byte_t merged;

    assign bus.idx = s_q.idx;
    assign bus.writing = (s_q.state == OTP_WRITE) || (s_q.state == OTP_REFRESH);
    assign bus.refresh_we = (s_q.state == OTP_REFRESH);
    assign bus.refresh_data = s_q.otp[s_q.idx];
    assign bus.done = s_q.done;
    assign bus.ok = s_q.ok;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        merged = s_q.otp[s_q.idx] | bus.shadow_byte;
        case (s_q.state)
            OTP_IDLE: begin
                if (bus.start) begin
                    s_d.state = OTP_DELAY;
                    s_d.cnt = '0;
                end
            end
            OTP_DELAY: begin
                // fixed wait between accepted command and first array write
                s_d.cnt = s_q.cnt + 20'h00001; // [RULE_13]
                if (s_q.cnt == 20'(PROG_DELAY_CYC - 1)) begin
                    s_d.state = OTP_WRITE;
                    s_d.cnt = '0;
                    s_d.idx = '0;
                    s_d.mism = 1'b0;
                end
            end
            OTP_WRITE: begin
                s_d.cnt = s_q.cnt + 20'h00001;
                if (s_q.cnt == 20'(BYTE_WRITE_CYC - 1)) begin
                    s_d.cnt = '0;
                    s_d.otp[s_q.idx] = merged;
                    s_d.mism = s_q.mism | (merged != bus.shadow_byte);
                    s_d.idx = s_q.idx + 5'h01;
                    if (s_q.idx == `PCH_LAST_BYTE) begin
                        s_d.state = OTP_REFRESH;
                    end
                end
            end
            OTP_REFRESH: begin
                // shadow copy reloaded from the array, one byte a cycle
                s_d.idx = s_q.idx + 5'h01; // [RULE_15]
                if (s_q.idx == `PCH_LAST_BYTE) begin
                    s_d.state = OTP_IDLE;
                    s_d.done = 1'b1;
                    s_d.ok = ~s_q.mism;
                end
            end
            default: begin
                s_d.state = OTP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : pch_otp_seq

// *** rtl/pch_cmd_handler.sv ***
// Purpose: programming-mode command interpreter on the two-wire current loop
// Assumes: BIT_SLOT marks the end of each command bit window; SYNC_PULSE marks a sync
// Notes: a bit is one when a sync pulse fell inside its window
//
// Summary of operation
// RULE_01: execute short frame starts array programming; replies OK 0x2AA or error.
// RULE_02: read long frame replies byte of addressed nibble then next byte.
// RULE_03: write long frame stores nibble, replies new byte and echoes nibble address.
// RULE_04: only sensor select 001 is served; others ignored without any reply.
// RULE_05: reply code 0x1E1 for good reception, 0x1E2 for reception error.
// RULE_06: first word is byte at nibble address halved; second is following byte.
// RULE_07: reading the last byte gives zero as second word.
// RULE_08: error replies carry fault number in four low bits, all else zero.
// RULE_09: framing faults give fault 0001, checksum faults give fault 0010.
// RULE_10: bad address gives 0101; locked write gives 0110 and changes nothing.
// RULE_11: fault numbers 0000, 0100 and 0111 upward are never sent.
// RULE_12: master enters mode, loads shadow bytes, then sends execute.
// RULE_13: a fixed delay passes between execute acceptance and array write start.
// RULE_14: sync pulses are ignored while the array write runs.
// RULE_15: success sets load-ok flag and reloads shadow bytes from the array.
// RULE_16: 3-bit checksum, x^3+x+1, seed 111, lsb first, three zeros appended.
// RULE_17: master stuffs a one after every three bits of the frame.
// RULE_18: a missing sync in a window aborts reception; next sync gets framing error.
// RULE_19: replies go out on consecutive syncs as 10-bit words with even parity.
// RULE_20: enter-mode replies OK 0x0CA; codes 101, 110, 000, 001 get no reply.
`timescale 1ns/1ns
`include "pch_defines.svh"

module pch_cmd_handler #(
    parameter int unsigned PROG_DELAY_CYC = `PCH_PROG_DELAY_CYC,
    parameter int unsigned BYTE_WRITE_CYC = `PCH_BYTE_WRITE_CYC,
    parameter int unsigned VALID_NIBBLES = `PCH_VALID_NIBBLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // command link
    input wire logic SYNC_PULSE,
    input wire logic BIT_SLOT,
    // reply transmitter
    output logic REPLY_STB,
    output pch_pkg::pch_word_t REPLY_WORD,
    output logic REPLY_PARITY,
    // status
    output logic PROG_ACTIVE
);
    import pch_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
        crc_step = {c[1:0], b} ^ (c[2] ? `PCH_CRC_POLY : 3'b000);
    endfunction : crc_step

    function automatic pch_words_t err_words(input logic [3:0] fault);
        err_words[0] = `PCH_RC_ERR;
        err_words[1] = {6'h00, fault};
        err_words[2] = `PCH_RD_ZERO;
    endfunction : err_words

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    pch_otp_if otp_bus ();

    pch_otp_seq #(
        .PROG_DELAY_CYC(PROG_DELAY_CYC),
        .BYTE_WRITE_CYC(BYTE_WRITE_CYC)
    ) u_seq (
        .clk(CLK),
        .reset_n(RESET_N),
        .bus(otp_bus)
    );

    pch_top_s s_q;
    pch_top_s s_d;

    assign otp_bus.start = s_q.otp_start;
    assign otp_bus.shadow_byte = s_q.shadow[otp_bus.idx];

    ////////////////////////////////////////////////////////////////////////////
    // receive, decode and reply

    always_comb begin
        logic sync_ok;
        logic slot_ok;
        logic bit_v;
        logic fin;
        logic crc_ok;
        logic [4:0] k;
        logic [4:0] mlen;
        logic [2:0] fc;
        logic [5:0] na;
        logic [4:0] bidx;
        pch_byte_t nb;
        sync_ok = 1'b0;
        slot_ok = 1'b0;
        bit_v = 1'b0;
        fin = 1'b0;
        crc_ok = 1'b0;
        k = '0;
        mlen = '0;
        fc = '0;
        na = '0;
        bidx = '0;
        nb = '0;
        s_d = s_q;
        s_d.reply_stb = 1'b0;
        s_d.otp_start = 1'b0;

        // link is deaf while the array is being written
        sync_ok = SYNC_PULSE & ~otp_bus.writing; // [RULE_14]
        slot_ok = BIT_SLOT & ~otp_bus.writing; // [RULE_14]
        bit_v = s_q.sync_seen | sync_ok;
        if (slot_ok) begin
            s_d.sync_seen = 1'b0;
        end else if (sync_ok) begin
            s_d.sync_seen = 1'b1;
        end

        case (s_q.state)
            RX_IDLE: begin
                if (slot_ok) begin
                    s_d.hist = {s_q.hist[1:0], bit_v};
                    if (s_d.hist == `PCH_START_PAT) begin
                        s_d.state = RX_DATA;
                        s_d.grp = 2'd0;
                        s_d.nbits = '0;
                        s_d.msg = '0;
                        s_d.rxcrc = '0;
                        s_d.crc = `PCH_CRC_SEED; // [RULE_16]
                    end
                end
            end
            RX_DATA: begin
                if (slot_ok && (s_q.grp == 2'd0)) begin
                    s_d.grp = 2'd1;
                    // a stuffing slot without sync means the sync was missed
                    if (!bit_v) begin // [RULE_17] [RULE_18]
                        s_d.state = RX_REPLY;
                        s_d.widx = 2'd0;
                        s_d.nwords = `PCH_WORDS_SHORT;
                        s_d.words = err_words(`PCH_FAULT_FRAMING); // [RULE_09]
                    end
                end else if (slot_ok) begin
                    s_d.grp = (s_q.grp == 2'd3) ? 2'd0 : s_q.grp + 2'd1;
                    k = s_q.nbits;
                    mlen = (k > `PCH_FC_BIT_IDX && !s_q.msg[5]) ?
                           `PCH_LONG_MSG_BITS : `PCH_SHORT_MSG_BITS;
                    if (k < mlen) begin
                        s_d.msg[k[3:0]] = bit_v;
                        s_d.crc = crc_step(s_q.crc, bit_v); // [RULE_16]
                    end else begin
                        s_d.rxcrc = {s_q.rxcrc[1:0], bit_v};
                    end
                    s_d.nbits = k + 5'd1;
                    fc = {bit_v, s_q.msg[4:3]};
                    if (k == `PCH_FC_BIT_IDX &&
                        (fc == `PCH_FC_XL0 || fc == `PCH_FC_XL1)) begin // [RULE_20]
                        s_d.state = RX_IDLE;
                        s_d.hist = '0;
                    end else if (k == 5'(mlen + `PCH_CRC_BITS - 5'd1)) begin
                        fin = 1'b1;
                    end
                end
            end
            RX_REPLY: begin
                s_d.sync_seen = 1'b0;
                // one word per sync, parity makes the count of ones even
                if (sync_ok) begin // [RULE_19]
                    s_d.reply_stb = 1'b1;
                    s_d.reply_word = s_q.words[s_q.widx];
                    s_d.reply_par = ^s_q.words[s_q.widx];
                    s_d.widx = s_q.widx + 2'd1;
                    if (s_q.widx + 2'd1 == s_q.nwords) begin
                        s_d.state = RX_IDLE;
                        s_d.hist = '0;
                    end
                end
            end
            default: begin
                s_d.state = RX_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////
        // end of frame

        if (fin) begin
            crc_ok = (crc_step(crc_step(crc_step(s_d.crc, 1'b0), 1'b0), 1'b0)
                      == s_d.rxcrc); // [RULE_16]
            fc = s_d.msg[5:3];
            na = s_d.msg[11:6];
            bidx = na[5:1]; // [RULE_06]
            s_d.state = RX_REPLY;
            s_d.widx = 2'd0;
            s_d.nwords = fc[2] ? `PCH_WORDS_SHORT : `PCH_WORDS_LONG;
            s_d.words[0] = `PCH_RC_OK; // [RULE_05]
            s_d.words[1] = `PCH_RD_ZERO;
            s_d.words[2] = `PCH_RD_ZERO;
            if (s_d.msg[2:0] != `PCH_SENSOR_SEL ||
                fc == `PCH_FC_BAD1 || fc == `PCH_FC_BAD2) begin // [RULE_04] [RULE_20]
                s_d.state = RX_IDLE;
                s_d.hist = '0;
            end else if (!crc_ok && fc == `PCH_FC_ENTER) begin // [RULE_20]
                s_d.state = RX_IDLE;
                s_d.hist = '0;
            end else if (!crc_ok) begin
                s_d.words = err_words(`PCH_FAULT_CRC); // [RULE_09] [RULE_08]
            end else begin
                case (fc)
                    `PCH_FC_ENTER: begin
                        s_d.prog = 1'b1;
                        s_d.words[1] = `PCH_RD_ENTER_OK; // [RULE_20]
                    end
                    `PCH_FC_EXEC: begin
                        // a programmed array refuses a second pass
                        if (s_q.lock) begin
                            s_d.words = err_words(`PCH_FAULT_WPROT); // [RULE_01]
                        end else begin
                            s_d.words[1] = `PCH_RD_EXEC_OK; // [RULE_01]
                            s_d.otp_start = 1'b1;
                        end
                    end
                    `PCH_FC_READ: begin
                        if ({1'b0, na} >= 7'(VALID_NIBBLES)) begin
                            s_d.words = err_words(`PCH_FAULT_RANGE); // [RULE_10] [RULE_02]
                        end else begin
                            s_d.words[1] = {2'b00, s_q.shadow[bidx]}; // [RULE_02] [RULE_06]
                            if (bidx != `PCH_LAST_BYTE) begin // [RULE_07]
                                s_d.words[2] = {2'b00, s_q.shadow[5'(bidx + 5'd1)]};
                            end
                        end
                    end
                    `PCH_FC_WRITE: begin
                        nb = s_q.shadow[bidx];
                        if (na[0]) begin
                            nb[7:4] = s_d.msg[15:12];
                        end else begin
                            nb[3:0] = s_d.msg[15:12];
                        end
                        if ({1'b0, na} >= 7'(VALID_NIBBLES)) begin
                            s_d.words = err_words(`PCH_FAULT_RANGE); // [RULE_10]
                        end else if (s_q.lock || bidx < `PCH_PROT_BYTES ||
                                     bidx == `PCH_SC_BYTE) begin
                            s_d.words = err_words(`PCH_FAULT_WPROT); // [RULE_10] [RULE_11]
                        end else begin
                            s_d.shadow[bidx] = nb; // [RULE_03]
                            s_d.words[1] = {2'b00, nb};
                            s_d.words[2] = {4'h0, na}; // [RULE_03]
                        end
                    end
                    default: begin
                        s_d.state = RX_IDLE;
                        s_d.hist = '0;
                    end
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // sequencer results

        if (otp_bus.refresh_we) begin
            s_d.shadow[otp_bus.idx] = otp_bus.refresh_data; // [RULE_15]
        end
        if (otp_bus.done) begin
            s_d.lock = 1'b1;
            s_d.shadow[`PCH_SC_BYTE][`PCH_LOAD_OK_BIT] = otp_bus.ok; // [RULE_15]
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign REPLY_STB = s_q.reply_stb;
    assign REPLY_WORD = s_q.reply_word;
    assign REPLY_PARITY = s_q.reply_par;
    assign PROG_ACTIVE = s_q.prog;

endmodule : pch_cmd_handler

// *** sim/pch_handler_properties.sv ***
// Purpose: concurrent checks on the reply side of the command handler
// Assumes: one clock, RESET_N asynchronous and active low
// Notes: attached to the handler by the bind at the foot of this file
`timescale 1ns/1ns

module pch_handler_properties #(
    parameter int unsigned PROG_DELAY_CYC = 20,
    parameter int unsigned BYTE_WRITE_CYC = 4,
    parameter int unsigned VALID_NIBBLES = 64
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // command link
    input wire logic SYNC_PULSE,
    input wire logic BIT_SLOT,
    // reply and status
    input wire logic REPLY_STB,
    input wire pch_pkg::pch_word_t REPLY_WORD,
    input wire logic REPLY_PARITY,
    input wire logic PROG_ACTIVE
);
    import pch_pkg::*;

    // last word handed out, to tell which word of a reply comes next
    pch_word_t last_q;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            last_q <= 10'h000;
        end else if (REPLY_STB) begin
            last_q <= REPLY_WORD;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_enter;
        $rose(PROG_ACTIVE);
    endsequence
    sequence s_ok_code;
        REPLY_STB && REPLY_WORD == 10'h1e1;
    endsequence
    sequence s_enter_data;
        REPLY_STB && REPLY_WORD == 10'h0ca;
    endsequence

    a_parity_even: assert property (REPLY_PARITY == ^REPLY_WORD)
        else $error("reply parity is not even");
    a_stb_on_sync: assert property (REPLY_STB |-> $past(SYNC_PULSE))
        else $error("reply word without a sync pulse");
    a_stb_single: assert property (REPLY_STB |=> !REPLY_STB)
        else $error("reply strobe longer than one cycle");
    a_word_holds: assert property (!REPLY_STB |-> $stable(REPLY_WORD))
        else $error("reply word moved between strobes");
    a_fault_known: assert property (REPLY_STB && last_q == 10'h1e2 |->
        REPLY_WORD inside {10'h001, 10'h002, 10'h005, 10'h006})
        else $error("fault word outside the supported set");
    a_ok_data: assert property (REPLY_STB && last_q == 10'h1e1 |->
        REPLY_WORD[9:8] == 2'b00 || REPLY_WORD == 10'h2aa)
        else $error("first data word wider than a byte");
    a_prog_sticky: assert property (PROG_ACTIVE |=> PROG_ACTIVE)
        else $error("programming mode dropped without reset");
    a_enter_reply: assert property (s_enter |-> ##[1:40] s_ok_code ##[2:20] s_enter_data)
        else $error("mode entry not answered with ok and its data word");
endmodule : pch_handler_properties

bind pch_cmd_handler pch_handler_properties #(
    .PROG_DELAY_CYC(PROG_DELAY_CYC),
    .BYTE_WRITE_CYC(BYTE_WRITE_CYC),
    .VALID_NIBBLES(VALID_NIBBLES)
) chk_u (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .SYNC_PULSE(SYNC_PULSE),
    .BIT_SLOT(BIT_SLOT),
    .REPLY_STB(REPLY_STB),
    .REPLY_WORD(REPLY_WORD),
    .REPLY_PARITY(REPLY_PARITY),
    .PROG_ACTIVE(PROG_ACTIVE)
);

// *** sim/pch_cmd_master.sv ***
// Purpose: command master sending frames and collecting reply words
// Assumes: one bit window lasts three clock cycles
// Notes: tasks are called by the testbench
`timescale 1ns/1ns

module pch_cmd_master (
    // clock
    input wire logic clk,
    // link toward the handler
    output logic sync_pulse,
    output logic bit_slot,
    // reply from the handler
    input wire logic reply_stb,
    input wire pch_pkg::pch_word_t reply_word
);
    import pch_pkg::*;

    initial begin
        sync_pulse = 1'b0;
        bit_slot = 1'b0;
    end

    task automatic send_bit(input logic b);
        @(posedge clk);
        sync_pulse <= b;
        bit_slot <= 1'b1;
        @(posedge clk);
        sync_pulse <= 1'b0;
        bit_slot <= 1'b0;
        @(posedge clk);
    endtask : send_bit

    // bad_slot names a stuffing slot sent as zero, -1 for none
    task automatic send_frame(input logic [15:0] msg, input int n, input bit with_crc,
                              input bit crc_ok, input int bad_slot);
        logic [2:0] c;
        logic [18:0] p;
        int tot;
        c = 3'b111;
        p = '0;
        for (int i = 0; i < n + 3; i++) begin
            c = {c[1:0], (i < n) ? msg[i] : 1'b0} ^ (c[2] ? 3'b011 : 3'b000);
        end
        if (!crc_ok) c = ~c;
        for (int i = 0; i < n; i++) p[i] = msg[i];
        {p[n], p[n + 1], p[n + 2]} = c;
        tot = with_crc ? n + 3 : n;
        for (int i = 0; i < 5; i++) send_bit(i != 2 && i != 4); // idle ones, then start 0,1,0
        for (int k = 0; k < tot; k++) begin
            if (k % 3 == 0) begin
                send_bit(k / 3 != bad_slot);
                if (k / 3 == bad_slot) return;
            end
            send_bit(p[k]);
        end
    endtask : send_frame

    task automatic sync_get(output pch_word_t w, output bit got);
        got = 1'b0;
        w = '0;
        @(posedge clk);
        sync_pulse <= 1'b1;
        @(posedge clk);
        sync_pulse <= 1'b0;
        repeat (3) begin
            #1;
            if (reply_stb === 1'b1) begin
                got = 1'b1;
                w = reply_word;
            end
            @(posedge clk);
        end
    endtask : sync_get
endmodule : pch_cmd_master

// *** sim/testbench.sv ***
// Purpose: self-checking bench of the programming-mode command handler
// Assumes: short delays set by parameter, shadow model kept in integers
// Notes: expected replies built in exp_q before each reply is checked
`timescale 1ns/1ns

module testbench;
    import pch_pkg::*;

    logic clk, reset_n, sync_pulse, bit_slot, reply_stb, reply_parity, prog_active;
    pch_word_t reply_word;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'hb5e36f9b;
    int sh[32];
    int exp_q[$];
    bit locked = 0;
    logic [2:0] bad_fc[4] = '{3'b101, 3'b110, 3'b000, 3'b001};
    int nas[6] = '{62, 63, 28, 0, 5, 4};
    int na;

    pch_cmd_handler #(.PROG_DELAY_CYC(20), .BYTE_WRITE_CYC(4), .VALID_NIBBLES(64)) dut_u (
        .CLK(clk), .RESET_N(reset_n), .SYNC_PULSE(sync_pulse), .BIT_SLOT(bit_slot),
        .REPLY_STB(reply_stb), .REPLY_WORD(reply_word), .REPLY_PARITY(reply_parity),
        .PROG_ACTIVE(prog_active));
    pch_cmd_master mst_u (.clk(clk), .sync_pulse(sync_pulse), .bit_slot(bit_slot),
        .reply_stb(reply_stb), .reply_word(reply_word));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_word(input pch_word_t got, input pch_word_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic check_reply();
        pch_word_t w;
        bit got;
        foreach (exp_q[i]) begin
            mst_u.sync_get(w, got);
            cmp_bit(got, 1'b1);
            cmp_word(w, 10'(exp_q[i]));
            cmp_bit(reply_parity, ^10'(exp_q[i]));
        end
    endtask : check_reply

    task automatic expect_none();
        pch_word_t w;
        bit got;
        mst_u.sync_get(w, got);
        cmp_bit(got, 1'b0);
    endtask : expect_none

    // long read or write with the shadow model updated first
    task automatic long_cmd(input logic [2:0] fc, input int n, input int d, input bit crc_ok);
        int b;
        b = n / 2;
        if (!crc_ok) exp_q = '{'h1e2, 'h002, 'h000};
        else if (fc == 3'b011 && (b < 2 || b == 14 || locked)) exp_q = '{'h1e2, 'h006, 'h000};
        else if (fc == 3'b011) begin
            sh[b] = (n % 2) ? (sh[b] & 'h0f) | (d << 4) : (sh[b] & 'hf0) | d;
            exp_q = '{'h1e1, sh[b], n};
        end else begin
            exp_q = '{'h1e1, sh[b], (b == 31) ? 0 : sh[b + 1]};
        end
        mst_u.send_frame({4'(d), 6'(n), fc, 3'b001}, 16, 1'b1, crc_ok, -1);
        check_reply();
    endtask : long_cmd

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        reset_n = 1'b0;
        foreach (sh[i]) sh[i] = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        cmp_bit(reply_stb, 1'b0);
        cmp_word(reply_word, 10'h000);
        cmp_bit(prog_active, 1'b0);
        $display("test reset done");
        for (int sa = 0; sa < 8; sa++) begin
            if (sa != 1) begin
                mst_u.send_frame({10'h000, 3'b111, 3'(sa)}, 6, 1'b1, 1'b1, -1);
                expect_none();
            end
        end
        foreach (bad_fc[i]) begin
            mst_u.send_frame({10'h000, bad_fc[i], 3'b001}, 6, bad_fc[i][2], 1'b1, -1);
            expect_none();
        end
        cmp_bit(prog_active, 1'b0);
        $display("test ignored frames done");
        mst_u.send_frame({10'h000, 3'b111, 3'b001}, 6, 1'b1, 1'b1, -1);
        exp_q = '{'h1e1, 'h0ca};
        check_reply();
        cmp_bit(prog_active, 1'b1);
        $display("test enter done");
        for (int i = 0; i < 22; i++) begin
            na = (i < 6) ? nas[i] : $random(seed) & 63;
            long_cmd(3'b011, na, $random(seed) & 15, 1'b1);
            long_cmd(3'b010, na, 0, 1'b1);
        end
        long_cmd(3'b010, 10, 0, 1'b0);
        mst_u.send_frame({4'h3, 6'd8, 3'b011, 3'b001}, 16, 1'b1, 1'b1, 2);
        exp_q = '{'h1e2, 'h001};
        check_reply();
        long_cmd(3'b010, 8, 0, 1'b1);
        $display("test read write done");
        mst_u.send_frame({10'h000, 3'b100, 3'b001}, 6, 1'b1, 1'b1, -1);
        exp_q = '{'h1e1, 'h2aa};
        check_reply();
        repeat (30) @(posedge clk);
        mst_u.send_frame({10'h000, 3'b111, 3'b001}, 6, 1'b1, 1'b1, -1);
        expect_none();
        repeat (300) @(posedge clk);
        sh[14] = 1;
        locked = 1;
        for (int b = 0; b < 32; b++) begin
            long_cmd(3'b010, 2 * b, 0, 1'b1);
        end
        long_cmd(3'b011, 40, 9, 1'b1);
        long_cmd(3'b010, 40, 0, 1'b1);
        mst_u.send_frame({10'h000, 3'b100, 3'b001}, 6, 1'b1, 1'b1, -1);
        exp_q = '{'h1e2, 'h006};
        check_reply();
        $display("test programming done");
        print_verdict();
    end
endmodule : testbench
